// ---- src/tpc_pwm_counter.sv ----
// Purpose: 8-bit timer/counter with compare channel A, PWM mode and prescaler
// Assumes: fast_periph_tick_in is a one-cycle strobe made on clk_sys_in
// Notes: Registers are reached over APB; one level interrupt output
//
// Overview of operation
// - PWM mode gives glitch-free 8-bit PWM
// - PWM counter runs 00 to top, restarts
// - Top match sets overflow flag, delayed
// - PWM pin action set by mode bits
// - PWM compare writes buffered until top
// - Compare readback returns buffered value
// - Compare at 00 or top holds pin
// - Interrupt needs flag, enable, global enable
// - PWM period is top plus one ticks
// - Clear on match resets counter after match, outside PWM mode
// - PWM enable resets counter after top
// - Normal mode match toggles, clears or sets
// - Clock select picks fast or core divider
// - Fast clock 25.6 MHz, synchronous timing
// - Flag cleared by ack, write one or status read
//
// The APB slave port is this design's own decision.
`timescale 1ns/10ps

module tpc_pwm_counter
	import tpc_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic srst_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	output logic pready_out,
	output logic pslverr_out,
	output logic [31:0] prdata_out,
	// Fast peripheral clock strobe
	input wire logic fast_periph_tick_in,
	// Interrupt vector taken
	input wire logic overflow_ack_in,
	input wire logic compare_a_ack_in,
	// Compare output pin and interrupt
	output logic compare_a_output_out,
	output logic compare_a_connected_out,
	output logic irq_out
);
	logic [7:0] control_q;
	logic [7:0] counter_value_q;
	logic [7:0] compare_a_q;
	logic [7:0] compare_buf_q;
	logic [7:0] top_value_q;
	logic [7:0] status_q;
	logic [7:0] mask_q;
	logic global_enable_q;
	logic [7:0] clear_pend_q;
	logic overflow_evt_q;
	logic compare_evt_q;
	logic pin_q;
	logic [TPC_CORE_DIV_W-1:0] core_div_q;
	logic [TPC_FAST_DIV_W-1:0] fast_div_q;
	logic [31:0] prdata_q;

	logic pwm_on;
	logic clear_on_match;
	logic [3:0] clk_sel;
	tpc_action_t action;
	logic timer_tick;
	logic at_top;
	logic at_compare;
	logic overflow_now;
	logic wr_acc;
	logic rd_acc;
	logic setup;
	logic mapped;
	logic [7:0] addr;
	logic [7:0] wbyte;

	// Low bits all ones: divider output lands on this cycle
	function automatic logic div_hit(input logic [TPC_CORE_DIV_W-1:0] cnt,
		input logic [3:0] log2_div);
		logic [TPC_CORE_DIV_W-1:0] msk;
		msk = TPC_CORE_DIV_W'((11'h001 << log2_div) - 11'h001);
		div_hit = (cnt & msk) == msk;
	endfunction

	function automatic logic addr_mapped(input logic [7:0] a);
		addr_mapped = (a == TPC_ADDR_CONTROL) || (a == TPC_ADDR_COUNTER) ||
			(a == TPC_ADDR_COMPARE_A) || (a == TPC_ADDR_TOP) ||
			(a == TPC_ADDR_STATUS) || (a == TPC_ADDR_MASK) ||
			(a == TPC_ADDR_GLOBAL);
	endfunction

	assign pwm_on = control_q[TPC_PWM_A_ENABLE_BIT];
	assign clear_on_match = control_q[TPC_CLEAR_ON_MATCH_BIT];
	assign clk_sel = control_q[TPC_CLKSEL_HI_BIT:TPC_CLKSEL_LO_BIT];
	assign action = tpc_action_t'(control_q[TPC_MODE_HI_BIT:TPC_MODE_LO_BIT]);

	assign addr = paddr_in[TPC_ADDR_W-1:0];
	assign mapped = (paddr_in[31:TPC_ADDR_W] == 24'h000000) && addr_mapped(addr);
	assign setup = psel_in && !penable_in;
	assign wr_acc = psel_in && penable_in && pwrite_in && mapped && pstrb_in[0];
	assign rd_acc = psel_in && penable_in && !pwrite_in && mapped;
	assign wbyte = pwdata_in[7:0];

	// APB answers in the access cycle with no wait states
	assign pready_out = psel_in && penable_in;
	assign pslverr_out = psel_in && penable_in && !mapped;
	assign prdata_out = prdata_q;

	// Prescalers run on core clock and on the fast strobe, both synchronous
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			core_div_q <= '0;
			fast_div_q <= '0;
		end else begin
			core_div_q <= core_div_q + 1'b1;
			if (fast_periph_tick_in) begin
				fast_div_q <= fast_div_q + 1'b1;
			end
		end
	end

	// Timer tick from the selected source
	always_comb begin
		timer_tick = 1'b0;
		if (clk_sel == TPC_CLKSEL_STOP) begin
			timer_tick = 1'b0;
		end else if (clk_sel <= TPC_CLKSEL_FAST_LAST) begin
			timer_tick = fast_periph_tick_in &&
				div_hit(TPC_CORE_DIV_W'(fast_div_q), clk_sel - 4'h1);
		end else begin
			timer_tick = div_hit(core_div_q, clk_sel - TPC_CLKSEL_CORE_FIRST);
		end
	end

	assign at_top = counter_value_q == top_value_q;
	assign at_compare = counter_value_q == compare_a_q;
	assign overflow_now = timer_tick && (pwm_on ? at_top : counter_value_q == TPC_COUNT_FULL);

	// Control register
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			control_q <= TPC_CONTROL_RST;
		end else if (wr_acc && addr == TPC_ADDR_CONTROL) begin
			control_q <= wbyte;
		end
	end

	// Top value register
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			top_value_q <= TPC_TOP_RST;
		end else if (wr_acc && addr == TPC_ADDR_TOP) begin
			top_value_q <= wbyte;
		end
	end

	// Mask keeps only the two implemented flag positions
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			mask_q <= TPC_FLAGS_RST;
		end else if (wr_acc && addr == TPC_ADDR_MASK) begin
			mask_q <= wbyte & ((8'h01 << TPC_COMPARE_A_FLAG_BIT) |
				(8'h01 << TPC_OVERFLOW_FLAG_BIT));
		end
	end

	// Global interrupt enable
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			global_enable_q <= 1'b0;
		end else if (wr_acc && addr == TPC_ADDR_GLOBAL) begin
			global_enable_q <= wbyte[TPC_GLOBAL_ENABLE_BIT];
		end
	end

	// Counter: wraps at top in PWM mode, clears after match when asked outside PWM mode
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			counter_value_q <= TPC_COUNTER_RST;
		end else if (wr_acc && addr == TPC_ADDR_COUNTER) begin
			counter_value_q <= wbyte;
		end else if (timer_tick) begin
			if (pwm_on && at_top) begin
				counter_value_q <= TPC_COUNT_ZERO;
			end else if (!pwm_on && clear_on_match && at_compare) begin
				counter_value_q <= TPC_COUNT_ZERO;
			end else begin
				counter_value_q <= counter_value_q + 8'h01;
			end
		end
	end

	// Compare A: buffered in PWM mode, latched at top
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			compare_buf_q <= TPC_COMPARE_RST;
			compare_a_q <= TPC_COMPARE_RST;
		end else begin
			if (wr_acc && addr == TPC_ADDR_COMPARE_A) begin
				compare_buf_q <= wbyte;
			end
			if (wr_acc && addr == TPC_ADDR_COMPARE_A && !pwm_on) begin
				compare_a_q <= wbyte;
			end else if (pwm_on && timer_tick && at_top) begin
				compare_a_q <= compare_buf_q;
			end
		end
	end

	// Output pin action
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			pin_q <= 1'b0;
		end else if (timer_tick) begin
			if (pwm_on) begin
				if (compare_a_q == TPC_COUNT_ZERO) begin
					pin_q <= (action == TPC_ACT_SET);
				end else if (compare_a_q == top_value_q) begin
					pin_q <= (action != TPC_ACT_SET);
				end else if (at_compare) begin
					pin_q <= (action == TPC_ACT_SET);
				end else if (counter_value_q == TPC_COUNT_ONE) begin
					pin_q <= (action != TPC_ACT_SET);
				end
			end else if (at_compare) begin
				case (action)
					TPC_ACT_TOGGLE: pin_q <= !pin_q;
					TPC_ACT_CLEAR: pin_q <= 1'b0;
					TPC_ACT_SET: pin_q <= 1'b1;
					default: pin_q <= pin_q;
				endcase
			end
		end
	end

	// Pin drives only when an action is chosen; port direction stays with software
	assign compare_a_output_out = pin_q;
	assign compare_a_connected_out = pwm_on ? action[1] : (action != TPC_ACT_OFF);

	// Events pass one synchronisation cycle before they set a flag
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			overflow_evt_q <= 1'b0;
			compare_evt_q <= 1'b0;
		end else begin
			overflow_evt_q <= overflow_now;
			compare_evt_q <= timer_tick && at_compare;
		end
	end

	// Write-one clear takes effect one cycle later
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			clear_pend_q <= TPC_FLAGS_RST;
		end else if (wr_acc && addr == TPC_ADDR_STATUS) begin
			clear_pend_q <= wbyte;
		end else begin
			clear_pend_q <= TPC_FLAGS_RST;
		end
	end

	// Sticky flags: set wins over every clear
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			status_q <= TPC_FLAGS_RST;
		end else begin
			if (overflow_evt_q) begin
				status_q[TPC_OVERFLOW_FLAG_BIT] <= 1'b1;
			end else if (overflow_ack_in || clear_pend_q[TPC_OVERFLOW_FLAG_BIT] ||
				(rd_acc && addr == TPC_ADDR_STATUS)) begin
				status_q[TPC_OVERFLOW_FLAG_BIT] <= 1'b0;
			end
			if (compare_evt_q) begin
				status_q[TPC_COMPARE_A_FLAG_BIT] <= 1'b1;
			end else if (compare_a_ack_in || clear_pend_q[TPC_COMPARE_A_FLAG_BIT] ||
				(rd_acc && addr == TPC_ADDR_STATUS)) begin
				status_q[TPC_COMPARE_A_FLAG_BIT] <= 1'b0;
			end
		end
	end

	assign irq_out = global_enable_q && ((status_q & mask_q) != 8'h00);

	// Read data captured in the setup cycle
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			prdata_q <= '0;
		end else if (setup) begin
			case (addr)
				TPC_ADDR_CONTROL: prdata_q <= {24'h000000, control_q};
				TPC_ADDR_COUNTER: prdata_q <= {24'h000000, counter_value_q};
				TPC_ADDR_COMPARE_A: prdata_q <= {24'h000000, compare_buf_q};
				TPC_ADDR_TOP: prdata_q <= {24'h000000, top_value_q};
				TPC_ADDR_STATUS: prdata_q <= {24'h000000, status_q};
				TPC_ADDR_MASK: prdata_q <= {24'h000000, mask_q};
				TPC_ADDR_GLOBAL: prdata_q <= {31'h00000000, global_enable_q};
				default: prdata_q <= '0;
			endcase
		end
	end
endmodule

// ---- src/tpc_pkg.sv ----
// Purpose: Constants shared by the PWM timer/counter block
// Assumes: 32-bit APB, byte addresses, one word per register
// Notes: Flag and mask registers share one bit layout
package tpc_pkg;
	// Register byte addresses
	localparam logic [7:0] TPC_ADDR_CONTROL = 8'h30;
	localparam logic [7:0] TPC_ADDR_COUNTER = 8'h34;
	localparam logic [7:0] TPC_ADDR_COMPARE_A = 8'h38;
	localparam logic [7:0] TPC_ADDR_TOP = 8'h3c;
	localparam logic [7:0] TPC_ADDR_STATUS = 8'h40;
	localparam logic [7:0] TPC_ADDR_MASK = 8'h44;
	localparam logic [7:0] TPC_ADDR_GLOBAL = 8'h48;
	localparam int TPC_ADDR_W = 8;

	// Control field positions
	localparam int TPC_CLEAR_ON_MATCH_BIT = 7;
	localparam int TPC_PWM_A_ENABLE_BIT = 6;
	localparam int TPC_MODE_HI_BIT = 5;
	localparam int TPC_MODE_LO_BIT = 4;
	localparam int TPC_CLKSEL_HI_BIT = 3;
	localparam int TPC_CLKSEL_LO_BIT = 0;

	// Status and mask field positions
	localparam int TPC_COMPARE_A_FLAG_BIT = 6;
	localparam int TPC_OVERFLOW_FLAG_BIT = 2;
	localparam int TPC_GLOBAL_ENABLE_BIT = 0;

	// Values after reset
	localparam logic [7:0] TPC_CONTROL_RST = 8'h00;
	localparam logic [7:0] TPC_COUNTER_RST = 8'h00;
	localparam logic [7:0] TPC_COMPARE_RST = 8'h00;
	localparam logic [7:0] TPC_TOP_RST = 8'hff;
	localparam logic [7:0] TPC_FLAGS_RST = 8'h00;

	// Counter landmarks
	localparam logic [7:0] TPC_COUNT_ZERO = 8'h00;
	localparam logic [7:0] TPC_COUNT_ONE = 8'h01;
	localparam logic [7:0] TPC_COUNT_FULL = 8'hff;

	// Clock selection codes
	localparam logic [3:0] TPC_CLKSEL_STOP = 4'h0;
	localparam logic [3:0] TPC_CLKSEL_FAST_LAST = 4'h4;
	localparam logic [3:0] TPC_CLKSEL_CORE_FIRST = 4'h5;
	localparam int TPC_CORE_DIV_W = 10;
	localparam int TPC_FAST_DIV_W = 3;

	// Rates
	localparam real TPC_CORE_MHZ = 25.0;
	localparam real TPC_FAST_MHZ = 25.6;

	// Compare output action codes
	typedef enum logic [1:0] {
		TPC_ACT_OFF = 2'b00,
		TPC_ACT_TOGGLE = 2'b01,
		TPC_ACT_CLEAR = 2'b10,
		TPC_ACT_SET = 2'b11
	} tpc_action_t;
endpackage

// ---- sim/tpc_pwm_counter_chk.sv ----
// Purpose: Port assertions for the PWM timer
// Assumes: Zero wait APB slave
// Notes: Mirrors control and global enable writes
`timescale 1ns/10ps
module tpc_chk
	import tpc_pkg::*;
(
	// Clock, reset and APB
	input wire logic clk_sys_in,
	input wire logic srst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [31:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [3:0] pstrb_in,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [31:0] prdata_out,
	// Pin and interrupt
	input wire logic compare_a_output_out,
	input wire logic compare_a_connected_out,
	input wire logic irq_out
);
	logic [7:0] ctrl_q;
	logic glob_q;
	logic wr;
	assign wr = psel_in && penable_in && pwrite_in && pstrb_in[0];
	always_ff @(posedge clk_sys_in) begin
		if (srst_in) begin
			ctrl_q <= TPC_CONTROL_RST;
			glob_q <= 1'b0;
		end else if (wr && paddr_in == {24'h0, TPC_ADDR_CONTROL}) begin
			ctrl_q <= pwdata_in[7:0];
		end else if (wr && paddr_in == {24'h0, TPC_ADDR_GLOBAL}) begin
			glob_q <= pwdata_in[TPC_GLOBAL_ENABLE_BIT];
		end
	end
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (srst_in);
	chk_ready_zero_wait: assert property (psel_in && penable_in |-> pready_out)
		else $error("pready missing in access phase");
	chk_err_unmapped: assert property (psel_in && penable_in && paddr_in == 32'h50 |-> pslverr_out)
		else $error("unmapped access not refused");
	chk_refused_zero: assert property (pslverr_out |-> pready_out && prdata_out == 32'h0)
		else $error("refused access returned data");
	chk_read_upper: assert property (pready_out && !pwrite_in |-> prdata_out[31:8] == 24'h0)
		else $error("upper read bits not zero");
	chk_irq_gate: assert property (irq_out |-> glob_q)
		else $error("interrupt without global enable");
	chk_pin_connect: assert property (compare_a_connected_out == (ctrl_q[5] || (ctrl_q[4] && !ctrl_q[6])))
		else $error("pin connection wrong for mode");
	chk_stop_hold: assert property ((ctrl_q[3:0] == 4'h0 && !wr)[*4] |=> $stable(compare_a_output_out))
		else $error("pin moved while stopped");
	chk_reset_quiet: assert property ($fell(srst_in) |-> !irq_out && !compare_a_output_out)
		else $error("outputs not quiet after reset");
	cov_irq: cover property (irq_out);
	cov_refused: cover property (pslverr_out);
	cov_pwm_rise: cover property (ctrl_q[6] && $rose(compare_a_output_out));
endmodule
bind tpc_pwm_counter tpc_chk u_chk (.clk_sys_in, .srst_in, .psel_in, .penable_in, .pwrite_in,
	.paddr_in, .pwdata_in, .pstrb_in, .pready_out, .pslverr_out, .prdata_out,
	.compare_a_output_out, .compare_a_connected_out, .irq_out);

// ---- sim/tpc_load.sv ----
// Purpose: Load on the compare output pin
// Assumes: Pull-down on the load side
// Notes: Sees the pin only while the timer drives it
`timescale 1ns/10ps
module tpc_load
	import tpc_pkg::*;
(
	// Pin from the timer
	input wire logic pin_in,
	input wire logic drive_in,
	// Level seen by the load
	output logic level_out
);
	assign level_out = drive_in ? pin_in : 1'b0;
endmodule

// ---- sim/tb_top.sv ----
// Purpose: Self-checking bench for the PWM timer
// Assumes: Zero wait APB, core clock 25 MHz
// Notes: Seeded random top and compare values
`timescale 1ns/10ps
module tb_top
	import tpc_pkg::*;
;
	logic clk_sys_in, srst_in, psel_in, penable_in, pwrite_in, fast_periph_tick_in;
	logic overflow_ack_in, pready_out, pslverr_out, irq_out, rerr, lvl;
	logic compare_a_output_out, compare_a_connected_out;
	logic [31:0] paddr_in, pwdata_in, prdata_out, rdv;
	int err_count, check_count, seed, t, c, m, e, n, hi, per, fcnt, f0;
	tpc_pwm_counter uut (.clk_sys_in, .srst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
		.pwdata_in, .pstrb_in(4'hf), .pready_out, .pslverr_out, .prdata_out,
		.fast_periph_tick_in, .overflow_ack_in, .compare_a_ack_in(1'b0),
		.compare_a_output_out, .compare_a_connected_out, .irq_out);
	tpc_load load (.pin_in(compare_a_output_out), .drive_in(compare_a_connected_out), .level_out(lvl));
	function automatic int exp_hi(int m, int t, int c);
		return (m == 3) ? t + 2 - c : c - 1;
	endfunction
	function automatic int exp_ext(int m, int e, int t);
		return (m == 1 || (m == 3) == (e == 1)) ? 0 : t + 1;
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= {24'h0, a};
		pwdata_in <= {24'h0, d};
		@(posedge clk_sys_in);
		penable_in <= 1'b1;
		@(posedge clk_sys_in);
		while (pready_out !== 1'b1) @(posedge clk_sys_in);
		rdv = prdata_out;
		rerr = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task automatic span(input logic v, output int k);
		k = 0;
		while (lvl === v && k < 600) begin
			@(posedge clk_sys_in);
			k++;
		end
	endtask
	task automatic meas();
		span(1'b1, n);
		span(1'b0, n);
		span(1'b1, hi);
		span(1'b0, per);
		per += hi;
	endtask
	task automatic irq_is(input logic v);
		@(posedge clk_sys_in);
		cmp({31'h0, irq_out}, {31'h0, v});
	endtask
	task automatic results();
		$display("checks=%0d errors=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		clk_sys_in = 1'b0;
		forever #20 clk_sys_in = ~clk_sys_in;
	end
	// Counts the fast strobes the design sees, for the fast clock selections
	always @(posedge clk_sys_in) begin
		fcnt <= fcnt + int'(fast_periph_tick_in);
		fast_periph_tick_in <= 1'($random(seed));
	end
	initial begin
		#2000000;
		err_count++;
		results();
	end
	initial begin
		seed = 30563;
		{srst_in, psel_in, penable_in, pwrite_in, overflow_ack_in} = 5'b10000;
		paddr_in = 32'h0;
		pwdata_in = 32'h0;
		repeat (10) @(posedge clk_sys_in);
		srst_in <= 1'b0;
		apb(1'b0, TPC_ADDR_CONTROL, 8'h00);
		cmp(rdv, 32'h0);
		apb(1'b0, 8'h50, 8'h00);
		cmp({31'h0, rerr}, 32'h1);
		for (int i = 0; i < 3; i++) begin
			t = 20 + ($random(seed) & 32'h3f);
			c = 2 + ($random(seed) & 32'hff) % (t - 3);
			m = 2 + (i & 1);
			apb(1'b1, TPC_ADDR_CONTROL, 8'h00);
			apb(1'b1, TPC_ADDR_TOP, t[7:0]);
			apb(1'b1, TPC_ADDR_COMPARE_A, c[7:0]);
			apb(1'b1, TPC_ADDR_CONTROL, {2'b01, m[1:0], 4'h5});
			meas();
			meas();
			cmp(per, t + 1);
			cmp(hi, exp_hi(m, t, c));
			c = t + 1 - c;
			apb(1'b1, TPC_ADDR_COMPARE_A, c[7:0]);
			apb(1'b0, TPC_ADDR_COMPARE_A, 8'h00);
			cmp(rdv, c);
			meas();
			meas();
			cmp(hi, exp_hi(m, t, c));
		end
		$display("test pwm done");
		for (m = 1; m < 4; m++) begin
			for (e = 0; e < 2; e++) begin
				apb(1'b1, TPC_ADDR_CONTROL, 8'h00);
				apb(1'b1, TPC_ADDR_COMPARE_A, e ? t[7:0] : 8'h00);
				apb(1'b1, TPC_ADDR_CONTROL, {2'b01, m[1:0], 4'h5});
				repeat (300) @(posedge clk_sys_in);
				hi = 0;
				repeat (t + 1) begin
					@(posedge clk_sys_in);
					hi += int'(lvl);
				end
				cmp(hi, exp_ext(m, e, t));
			end
		end
		$display("test extremes done");
		apb(1'b1, TPC_ADDR_MASK, 8'h04);
		irq_is(1'b0);
		apb(1'b1, TPC_ADDR_GLOBAL, 8'h01);
		irq_is(1'b1);
		apb(1'b1, TPC_ADDR_CONTROL, 8'h00);
		apb(1'b0, TPC_ADDR_STATUS, 8'h00);
		cmp(rdv & 32'h4, 32'h4);
		irq_is(1'b0);
		apb(1'b1, TPC_ADDR_CONTROL, 8'h45);
		repeat (t + 4) @(posedge clk_sys_in);
		irq_is(1'b1);
		apb(1'b1, TPC_ADDR_CONTROL, 8'h00);
		apb(1'b1, TPC_ADDR_MASK, 8'h00);
		irq_is(1'b0);
		apb(1'b1, TPC_ADDR_MASK, 8'h04);
		irq_is(1'b1);
		overflow_ack_in <= 1'b1;
		@(posedge clk_sys_in);
		overflow_ack_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		irq_is(1'b0);
		$display("test irq done");
		for (m = 1; m < 9; m++) begin
			apb(1'b0, TPC_ADDR_COUNTER, 8'h00);
			n = rdv;
			apb(1'b1, TPC_ADDR_CONTROL, {4'h0, m[3:0]});
			f0 = fcnt;
			repeat (64) @(posedge clk_sys_in);
			apb(1'b1, TPC_ADDR_CONTROL, 8'h00);
			f0 = fcnt - f0;
			apb(1'b0, TPC_ADDR_COUNTER, 8'h00);
			if (m < 5) begin
				cmp({31'h0, ((rdv - n + 2) & 32'hff) - (f0 >> (m - 1)) <= 4}, 32'h1);
			end else begin
				cmp({31'h0, ((rdv - n + 1) & 32'hff) - (67 >> (m - 5)) <= 2}, 32'h1);
			end
		end
		apb(1'b1, TPC_ADDR_COMPARE_A, 8'h09);
		apb(1'b1, TPC_ADDR_CONTROL, 8'h95);
		repeat (300) @(posedge clk_sys_in);
		meas();
		cmp(per, 32'd20);
		repeat (5) begin
			apb(1'b0, TPC_ADDR_COUNTER, 8'h00);
			cmp({31'h0, rdv <= 32'h9}, 32'h1);
		end
		apb(1'b1, TPC_ADDR_CONTROL, 8'ha5);
		repeat (20) @(posedge clk_sys_in);
		cmp({31'h0, lvl}, 32'h0);
		apb(1'b1, TPC_ADDR_CONTROL, 8'hb5);
		repeat (20) @(posedge clk_sys_in);
		cmp({31'h0, lvl}, 32'h1);
		$display("test counter done");
		results();
	end
endmodule
